// ---- design/tvf_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module tvf_regs (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// link side
	input wire logic linkClk,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdWdata,
	output logic cmdReady,
	output logic rspValid,
	output logic [15:0] rspData,
	// pins
	input wire logic syncResetPinN,
	input wire logic ssDetectLowPin,
	input wire logic ssDetectHighPin,
	// converter logic on mclk
	input wire logic softstartDetectDisable,
	input wire logic [1:0] loopScale,
	input wire logic maskVminWarn,
	input wire logic maskInvalidData,
	input wire logic adcValid,
	input wire logic [15:0] voutAdc,
	input wire logic [11:0] ioutAdc,
	input wire logic [10:0] tempAdc,
	input wire logic voutCmdStrobe,
	input wire logic [15:0] voutCmdValue,
	input wire logic [15:0] bootVout,
	output logic [15:0] voutTarget,
	output logic resetVoutRequest,
	output logic alertN
);
	// ==========================================================
	// link domain: request capture and answer
	logic reqTgl_r;
	logic reqWrite_r;
	logic [7:0] reqCode_r;
	logic [15:0] reqData_r;
	logic ackTgl_r;
	logic ackSync;
	logic ackSeen_r;
	logic [15:0] rspWord_r;

	tvf_sync #(.WIDTH(1)) ackSyncInst (
		.clk(linkClk),
		.resetn(resetn),
		.ce(1'b1),
		.d(ackTgl_r),
		.q(ackSync)
	);

	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			reqTgl_r <= 1'b0;
			reqWrite_r <= 1'b0;
			reqCode_r <= 8'h00;
			reqData_r <= 16'h0000;
			cmdReady <= 1'b1;
		end else if (cmdValid && cmdReady) begin
			reqTgl_r <= ~reqTgl_r;
			reqWrite_r <= cmdWrite;
			reqCode_r <= cmdCode;
			reqData_r <= cmdWdata;
			cmdReady <= 1'b0;
		end else if (ackSync != ackSeen_r) begin
			cmdReady <= 1'b1;
		end
	end

	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			ackSeen_r <= 1'b0;
			rspValid <= 1'b0;
			rspData <= 16'h0000;
		end else begin
			ackSeen_r <= ackSync;
			rspValid <= ackSync != ackSeen_r;
			if (ackSync != ackSeen_r) begin
				rspData <= rspWord_r;
			end
		end
	end

	// ==========================================================
	// core domain: crossing in and pin synchronisers
	logic reqSync;
	logic reqSeen_r;
	logic reqEv;
	logic [2:0] pinSync;
	logic syncResetLow;
	logic ssDetectFault;

	tvf_sync #(.WIDTH(1)) reqSyncInst (
		.clk(mclk),
		.resetn(resetn),
		.ce(ce),
		.d(reqTgl_r),
		.q(reqSync)
	);

	tvf_sync #(.WIDTH(3)) pinSyncInst (
		.clk(mclk),
		.resetn(resetn),
		.ce(ce),
		.d({~syncResetPinN, ssDetectLowPin, ssDetectHighPin}),
		.q(pinSync)
	);

	assign syncResetLow = pinSync[2];
	assign ssDetectFault = pinSync[1] | pinSync[0];
	assign reqEv = reqSync != reqSeen_r;

	// request fields stay still until the answer toggles back
	logic wrEv;
	logic clearFaults;
	logic floorWr;
	logic mfrWr;
	logic cmlWr;
	logic knownRead;
	logic badCmd;

	assign wrEv = reqEv & reqWrite_r;
	assign clearFaults = wrEv & (reqCode_r == tvf_pkg::CMD_CLEAR_FAULTS);
	assign floorWr = wrEv & (reqCode_r == tvf_pkg::CMD_OUTPUT_VOLTAGE_FLOOR);
	assign mfrWr = wrEv & (reqCode_r == tvf_pkg::CMD_STATUS_MFR);
	assign cmlWr = wrEv & (reqCode_r == tvf_pkg::CMD_STATUS_CML);

	always_comb begin
		case (reqCode_r)
			tvf_pkg::CMD_STATUS_BYTE,
			tvf_pkg::CMD_STATUS_WORD,
			tvf_pkg::CMD_STATUS_CML,
			tvf_pkg::CMD_STATUS_MFR,
			tvf_pkg::CMD_OUTPUT_VOLTAGE_TELEMETRY,
			tvf_pkg::CMD_OUTPUT_CURRENT_TELEMETRY,
			tvf_pkg::CMD_EXTERNAL_TEMPERATURE_TELEMETRY,
			tvf_pkg::CMD_PROTOCOL_REVISION_BYTE,
			tvf_pkg::CMD_OUTPUT_VOLTAGE_FLOOR: knownRead = 1'b1;
			default: knownRead = 1'b0;
		endcase
	end

	assign badCmd = reqEv & ~clearFaults & ~floorWr & ~mfrWr & ~cmlWr & (reqWrite_r | ~knownRead);

	// ==========================================================
	// floor register and write checking
	logic initDone_r;
	logic [11:0] floor_r;
	logic [15:0] voutCmd_r;
	logic [11:0] floorLo;
	logic [11:0] floorHi;
	logic [11:0] floorReq;
	logic floorInRange;
	logic floorAbove;
	logic floorBelow;
	logic floorInvalid;

	always_comb begin
		case (loopScale)
			tvf_pkg::SCALE_HALF: begin
				floorLo = tvf_pkg::FLOOR_LO_HALF;
				floorHi = tvf_pkg::FLOOR_HI_HALF;
			end
			tvf_pkg::SCALE_QUARTER: begin
				floorLo = tvf_pkg::FLOOR_LO_QUARTER;
				floorHi = tvf_pkg::FLOOR_HI_QUARTER;
			end
			default: begin
				floorLo = tvf_pkg::FLOOR_LO_1;
				floorHi = tvf_pkg::FLOOR_HI_1;
			end
		endcase
	end

	assign floorReq = reqData_r[11:0];
	assign floorInRange = (floorReq >= floorLo) && (floorReq <= floorHi);
	assign floorAbove = {4'h0, floorReq} > voutCmd_r;
	assign floorBelow = {4'h0, floorReq} < voutCmd_r;
	assign floorInvalid = ~(floorInRange & ~floorAbove);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			initDone_r <= 1'b0;
			floor_r <= 12'h000;
		end else if (ce) begin
			initDone_r <= 1'b1;
			if (!initDone_r) begin
				floor_r <= floorLo;
			end else if (floorWr) begin
				if (!floorInvalid) begin
					floor_r <= floorReq;
				end else if (!floorInRange && floorBelow) begin
					floor_r <= floorLo;
				end
				// in range but above the command, or out of range and not below it: contents kept
			end
		end
	end

	// ==========================================================
	// voltage target clamp
	logic [15:0] floorWide;
	logic cmdBelowFloor;
	logic [15:0] wantTarget;

	assign floorWide = {4'h0, floor_r};
	assign cmdBelowFloor = voutCmdStrobe & (voutCmdValue < floorWide);

	always_comb begin
		if (syncResetLow) begin
			wantTarget = bootVout;
		end else begin
			wantTarget = voutCmd_r;
		end
		if (wantTarget < floorWide) begin
			wantTarget = floorWide;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			voutCmd_r <= 16'h0000;
			voutTarget <= 16'h0000;
			resetVoutRequest <= 1'b0;
		end else if (ce) begin
			if (!initDone_r) begin
				voutCmd_r <= bootVout;
			end else if (voutCmdStrobe) begin
				voutCmd_r <= voutCmdValue;
			end
			voutTarget <= wantTarget;
			resetVoutRequest <= syncResetLow;
		end
	end

	// ==========================================================
	// status flags: a set in the same cycle as a clear wins
	logic ssErr_r;
	logic resetVoutFlag_r;
	logic vminWarn_r;
	logic other_r;
	logic ivd_r;
	logic ivc_r;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ssErr_r <= 1'b0;
		end else if (ce) begin
			ssErr_r <= ssDetectFault | (ssErr_r & ~clearFaults & ~(mfrWr & reqData_r[tvf_pkg::MFR_SS_ERR_BIT]));
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			resetVoutFlag_r <= 1'b0;
		end else if (ce) begin
			resetVoutFlag_r <= syncResetLow | (resetVoutFlag_r & ~clearFaults);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			vminWarn_r <= 1'b0;
			other_r <= 1'b0;
		end else if (ce) begin
			vminWarn_r <= cmdBelowFloor | (vminWarn_r & ~clearFaults & ~(mfrWr & reqData_r[tvf_pkg::MFR_VMIN_WARN_BIT]));
			other_r <= cmdBelowFloor | (other_r & ~clearFaults);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ivd_r <= 1'b0;
			ivc_r <= 1'b0;
		end else if (ce) begin
			ivd_r <= (floorWr & floorInvalid) | (ivd_r & ~clearFaults & ~(cmlWr & reqData_r[tvf_pkg::CML_IVD_BIT]));
			ivc_r <= badCmd | (ivc_r & ~clearFaults & ~(cmlWr & reqData_r[tvf_pkg::CML_IVC_BIT]));
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			alertN <= 1'b1;
		end else if (ce) begin
			// soft-start and reset-pin flags never reach the alert
			alertN <= ~((vminWarn_r & ~maskVminWarn) | ((ivd_r | ivc_r) & ~maskInvalidData));
		end
	end

	// ==========================================================
	// telemetry words
	logic [15:0] voutTel_r;
	logic [15:0] ioutTel_r;
	logic [15:0] tempTel_r;
	logic [9:0] ioutCount;

	always_comb begin
		if (ioutAdc[11]) begin
			ioutCount = 10'h000;
		end else if (ioutAdc[10:0] > {1'b0, tvf_pkg::IOUT_MAX_COUNT}) begin
			ioutCount = tvf_pkg::IOUT_MAX_COUNT;
		end else begin
			ioutCount = ioutAdc[9:0];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			voutTel_r <= tvf_pkg::RST_OUTPUT_VOLTAGE_TELEMETRY;
			ioutTel_r <= tvf_pkg::RST_OUTPUT_CURRENT_TELEMETRY;
			tempTel_r <= tvf_pkg::RST_EXTERNAL_TEMPERATURE_TELEMETRY;
		end else if (ce) begin
			if (adcValid) begin
				voutTel_r <= voutAdc;
				ioutTel_r <= {tvf_pkg::IOUT_EXPONENT, 1'b0, ioutCount};
			end
			if (!softstartDetectDisable) begin
				tempTel_r <= {tvf_pkg::TEMP_EXPONENT, tvf_pkg::TEMP_DEFAULT};
			end else if (adcValid) begin
				tempTel_r <= {tvf_pkg::TEMP_EXPONENT, tempAdc};
			end
		end
	end

	// ==========================================================
	// read mux and answer
	logic [7:0] statusByte;
	logic [7:0] statusMfr;
	logic [7:0] statusCml;
	logic [15:0] rdWord;

	always_comb begin
		statusMfr = 8'h00;
		statusMfr[tvf_pkg::MFR_SS_ERR_BIT] = ssErr_r;
		statusMfr[tvf_pkg::MFR_RESET_VOUT_BIT] = resetVoutFlag_r;
		statusMfr[tvf_pkg::MFR_VMIN_WARN_BIT] = vminWarn_r;
		statusCml = 8'h00;
		statusCml[tvf_pkg::CML_IVC_BIT] = ivc_r;
		statusCml[tvf_pkg::CML_IVD_BIT] = ivd_r;
		statusByte = 8'h00;
		statusByte[tvf_pkg::SBYTE_CML_BIT] = ivd_r | ivc_r;
		statusByte[tvf_pkg::SBYTE_OTHER_BIT] = other_r;
	end

	always_comb begin
		case (reqCode_r)
			tvf_pkg::CMD_STATUS_BYTE: rdWord = {8'h00, statusByte};
			tvf_pkg::CMD_STATUS_WORD: rdWord = {3'h0, |statusMfr, 4'h0, statusByte};
			tvf_pkg::CMD_STATUS_CML: rdWord = {8'h00, statusCml};
			tvf_pkg::CMD_STATUS_MFR: rdWord = {8'h00, statusMfr};
			tvf_pkg::CMD_OUTPUT_VOLTAGE_TELEMETRY: rdWord = voutTel_r;
			tvf_pkg::CMD_OUTPUT_CURRENT_TELEMETRY: rdWord = ioutTel_r;
			tvf_pkg::CMD_EXTERNAL_TEMPERATURE_TELEMETRY: rdWord = tempTel_r;
			tvf_pkg::CMD_PROTOCOL_REVISION_BYTE: rdWord = {8'h00, tvf_pkg::PROTOCOL_REVISION_VALUE};
			// exponent lives in the mode setting, upper nibble reads zero
			tvf_pkg::CMD_OUTPUT_VOLTAGE_FLOOR: rdWord = {4'h0, floor_r};
			default: rdWord = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reqSeen_r <= 1'b0;
			ackTgl_r <= 1'b0;
			rspWord_r <= 16'h0000;
		end else if (ce) begin
			reqSeen_r <= reqSync;
			if (reqEv) begin
				rspWord_r <= reqWrite_r ? 16'h0000 : rdWord;
				ackTgl_r <= ~ackTgl_r;
			end
		end
	end
endmodule : tvf_regs
`default_nettype wire

// ---- design/tvf_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module tvf_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1_r <= '0;
			q <= '0;
		end else if (ce) begin
			stage1_r <= d;
			q <= stage1_r;
		end
	end
endmodule : tvf_sync
`default_nettype wire

// ---- include/tvf_pkg.sv ----
package tvf_pkg;
	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
	localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_TELEMETRY = 8'h8B;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_TELEMETRY = 8'h8C;
	localparam logic [7:0] CMD_EXTERNAL_TEMPERATURE_TELEMETRY = 8'h8E;
	localparam logic [7:0] CMD_PROTOCOL_REVISION_BYTE = 8'h98;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FLOOR = 8'hA4;
	// ==========================================================
	// reset values and fixed fields
	localparam logic [15:0] RST_OUTPUT_VOLTAGE_TELEMETRY = 16'h0000;
	localparam logic [15:0] RST_OUTPUT_CURRENT_TELEMETRY = 16'hE000;
	localparam logic [15:0] RST_EXTERNAL_TEMPERATURE_TELEMETRY = 16'h0019;
	localparam logic [7:0] PROTOCOL_REVISION_VALUE = 8'h12;
	localparam logic [4:0] VOUT_EXPONENT = 5'h17;
	localparam logic [4:0] IOUT_EXPONENT = 5'h1C;
	localparam logic [4:0] TEMP_EXPONENT = 5'h00;
	localparam logic [9:0] IOUT_MAX_COUNT = 10'h280;
	localparam logic [10:0] TEMP_DEFAULT = 11'h019;
	// ==========================================================
	// floor ranges per loop scale
	localparam logic [1:0] SCALE_1 = 2'h0;
	localparam logic [1:0] SCALE_HALF = 2'h1;
	localparam logic [1:0] SCALE_QUARTER = 2'h2;
	localparam logic [11:0] FLOOR_LO_1 = 12'h100;
	localparam logic [11:0] FLOOR_HI_1 = 12'h2E6;
	localparam logic [11:0] FLOOR_LO_HALF = 12'h200;
	localparam logic [11:0] FLOOR_HI_HALF = 12'h5CC;
	localparam logic [11:0] FLOOR_LO_QUARTER = 12'h400;
	localparam logic [11:0] FLOOR_HI_QUARTER = 12'hB98;
	// ==========================================================
	// status bit positions
	localparam int MFR_SS_ERR_BIT = 3;
	localparam int MFR_RESET_VOUT_BIT = 2;
	localparam int MFR_VMIN_WARN_BIT = 1;
	localparam int CML_IVC_BIT = 7;
	localparam int CML_IVD_BIT = 6;
	localparam int SBYTE_CML_BIT = 1;
	localparam int SBYTE_OTHER_BIT = 0;
	localparam int SWORD_MFR_BIT = 4;
endpackage : tvf_pkg

// ---- sim/tvf_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module tvf_host_model (
	input wire logic linkClk,
	input wire logic cmdReady,
	input wire logic rspValid,
	output logic cmdValid,
	output logic cmdWrite,
	output logic [7:0] cmdCode,
	output logic [15:0] cmdWdata,
	output logic lost
);
	initial begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'h00;
		cmdWdata = 16'h0000;
		lost = 1'b0;
	end
	// ==========
	// one request held until taken, then its answer awaited
	task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
		int n;
		n = 0;
		@(posedge linkClk);
		#0.5;
		cmdValid = 1'b1;
		cmdWrite = wr;
		cmdCode = code;
		cmdWdata = (code == 8'hA4) ? {4'h0, data[11:0]} : data;
		do begin
			@(posedge linkClk);
			n++;
		end while (cmdReady !== 1'b1 && n < 50);
		#0.5;
		// released fields stop showing the request
		cmdValid = 1'b0;
		cmdWrite = ~wr;
		cmdCode = ~code;
		cmdWdata = ~cmdWdata;
		while (rspValid !== 1'b1 && n < 100) begin
			@(posedge linkClk);
			n++;
		end
		if (n >= 100)
			lost = 1'b1;
	endtask : send
endmodule : tvf_host_model
`default_nettype wire

// ---- sim/tvf_regs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module tvf_regs_monitor (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic linkClk,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire logic rspValid,
	input wire logic syncResetPinN,
	input wire logic ssDetectLowPin,
	input wire logic maskVminWarn,
	input wire logic voutCmdStrobe,
	input wire logic [15:0] voutCmdValue,
	input wire logic [15:0] voutTarget,
	input wire logic resetVoutRequest,
	input wire logic alertN
);
	// ==========
	// link handshake
	sequence taken_s;
		cmdValid && cmdReady;
	endsequence : taken_s
	sequence low_cmd_s;
		ce && voutCmdStrobe && voutCmdValue < 16'h0100;
	endsequence : low_cmd_s
	take_drop_a: assert property (
		@(posedge linkClk) disable iff (!resetn) taken_s |=> !cmdReady
	) else $error("ready kept");
	answer_time_a: assert property (
		@(posedge linkClk) disable iff (!resetn) taken_s |-> ##[2:40] rspValid
	) else $error("no answer");
	rsp_pulse_a: assert property (
		@(posedge linkClk) disable iff (!resetn) rspValid |=> !rspValid
	) else $error("answer too long");
	ready_back_a: assert property (
		@(posedge linkClk) disable iff (!resetn) $rose(cmdReady) |-> rspValid
	) else $error("ready without answer");
	// ==========
	// core side
	floor_clamp_a: assert property (
		@(posedge mclk) disable iff (!resetn) low_cmd_s |-> ##[1:3] voutTarget >= 16'h0100
	) else $error("target below floor");
	vmin_alert_a: assert property (
		@(posedge mclk) disable iff (!resetn) low_cmd_s and !maskVminWarn |-> ##[1:3] !alertN
	) else $error("no alert on low command");
	cmd_follow_a: assert property (
		@(posedge mclk) disable iff (!resetn) ce && voutCmdStrobe && voutCmdValue > 16'h0B98 && syncResetPinN
		|-> (##1 voutTarget == $past(voutCmdValue)) or (##2 voutTarget == $past(voutCmdValue, 2))
	) else $error("target not command");
	reset_req_a: assert property (
		@(posedge mclk) disable iff (!resetn) $fell(syncResetPinN) |-> ##[2:4] resetVoutRequest
	) else $error("no reset request");
	reset_quiet_a: assert property (
		@(posedge mclk) disable iff (!resetn) $rose(resetVoutRequest) && alertN |=> alertN [*4]
	) else $error("alert on reset pin");
	ss_quiet_a: assert property (
		@(posedge mclk) disable iff (!resetn) $rose(ssDetectLowPin) && alertN |=> alertN [*8]
	) else $error("alert on pin fault");
endmodule : tvf_regs_monitor
bind tvf_regs tvf_regs_monitor mon (.mclk, .resetn, .ce, .linkClk, .cmdValid, .cmdReady, .rspValid, .syncResetPinN,
	.ssDetectLowPin, .maskVminWarn, .voutCmdStrobe, .voutCmdValue, .voutTarget, .resetVoutRequest, .alertN);
`default_nettype wire

// ---- sim/tvf_regs_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module tvf_regs_test;
	logic mclk = 1'b0, resetn = 1'b0, ce = 1'b1, linkClk = 1'b0, syncResetPinN = 1'b1;
	logic ssDetectLowPin = 1'b0, ssDetectHighPin = 1'b0, softstartDetectDisable = 1'b0, maskInvalidData = 1'b0;
	logic maskVminWarn = 1'b0, adcValid = 1'b0, voutCmdStrobe = 1'b0;
	logic [1:0] loopScale = 2'h0;
	logic [15:0] voutAdc = 16'h0000, voutCmdValue = 16'h0000, bootVout = 16'h0200;
	logic [11:0] ioutAdc = 12'h000, i;
	logic [10:0] tempAdc = 11'h000;
	logic cmdValid, cmdWrite, cmdReady, rspValid, resetVoutRequest, alertN, lost;
	logic [7:0] cmdCode;
	logic [15:0] cmdWdata, rspData, voutTarget, v;
	logic [15:0] expQ[$];
	logic [7:0] codeQ[$];
	int errors = 0, cmp_count = 0;
	logic [11:0] lo[3] = '{tvf_pkg::FLOOR_LO_1, tvf_pkg::FLOOR_LO_HALF, tvf_pkg::FLOOR_LO_QUARTER};
	logic [15:0] fw[5] = '{16'h0250, 16'h0150, 16'h0050, 16'h02E6, 16'h02E7};
	logic [15:0] fe[5] = '{16'h0100, 16'h0150, 16'h0100, 16'h02E6, 16'h0100};
	logic fv[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	initial forever #2.5 mclk = ~mclk;
	initial begin
		#1.3;
		forever #3 linkClk = ~linkClk;
	end
	tvf_regs dut (.mclk, .resetn, .ce, .linkClk, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata, .cmdReady, .rspValid,
		.rspData, .syncResetPinN, .ssDetectLowPin, .ssDetectHighPin, .softstartDetectDisable, .loopScale,
		.maskVminWarn, .maskInvalidData, .adcValid, .voutAdc, .ioutAdc, .tempAdc, .voutCmdStrobe, .voutCmdValue,
		.bootVout, .voutTarget, .resetVoutRequest, .alertN);
	tvf_host_model host (.linkClk, .cmdReady, .rspValid, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata, .lost);
	// ==========
	// tasks
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_level(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_level
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		expQ.push_back(e);
		codeQ.push_back(c);
		host.send(1'b0, c, 16'h0000);
	endtask : rd
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		expQ.push_back(16'h0000);
		codeQ.push_back(c);
		host.send(1'b1, c, d);
	endtask : wr
	// s high: voltage command, else a conversion
	task automatic pulse(input logic s, input logic [15:0] val, input logic [11:0] cur, input logic [10:0] t);
		@(negedge mclk);
		{voutCmdStrobe, adcValid} = {s, ~s};
		voutCmdValue = val;
		voutAdc = val;
		ioutAdc = cur;
		tempAdc = t;
		@(negedge mclk);
		{voutCmdStrobe, adcValid} = 2'b00;
		voutCmdValue = ~val;
		repeat (4) @(negedge mclk);
	endtask : pulse
	task automatic rst(input logic [1:0] s);
		@(negedge mclk);
		resetn = 1'b0;
		loopScale = s;
		repeat (20) @(negedge mclk);
		resetn = 1'b1;
		repeat (6) @(negedge mclk);
	endtask : rst
	task automatic summarize();
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// ==========
	// answer checking and hang guard
	always @(posedge linkClk) begin
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0) begin
				errors++;
				$display("[FAIL] spare answer expected none seen %h", rspData);
			end else
				chk($sformatf("code %h", codeQ.pop_front()), expQ.pop_front(), rspData);
		end
	end
	always @(posedge lost) begin
		errors++;
		summarize();
	end
	// ==========
	// sequence
	initial begin
		v = 16'($urandom(32'h0529d0ec));
		for (int s = 2; s >= 0; s--) begin
			rst(2'(s));
			rd(8'hA4, {4'h0, lo[s]});
		end
		chk("target", 16'h0200, voutTarget);
		rd(8'h8B, 16'h0000);
		rd(8'h8C, 16'hE000);
		rd(8'h8E, 16'h0019);
		rd(8'h98, 16'h0012);
		pulse(1'b0, v, 12'hFFB, 11'h05A);
		rd(8'h8B, v);
		rd(8'h8C, 16'hE000);
		rd(8'h8E, 16'h0019);
		@(negedge mclk) softstartDetectDisable = 1'b1;
		pulse(1'b0, v, 12'h2BC, 11'h05A);
		rd(8'h8C, 16'hE280);
		rd(8'h8E, 16'h005A);
		i = 12'($urandom_range(639));
		pulse(1'b0, v, i, 11'h7FF);
		rd(8'h8C, {6'h38, i[9:0]});
		rd(8'h8E, 16'h07FF);
		@(negedge mclk) softstartDetectDisable = 1'b0;
		pulse(1'b1, 16'h0080, 12'h000, 11'h000);
		chk("target", 16'h0100, voutTarget);
		chk_level("alert", 1'b0, alertN);
		rd(8'h80, 16'h0002);
		rd(8'h78, 16'h0001);
		rd(8'h79, 16'h1001);
		wr(8'h80, 16'h0002);
		repeat (3) @(negedge mclk);
		chk_level("alert", 1'b1, alertN);
		wr(8'h03, 16'h0000);
		@(negedge mclk) maskVminWarn = 1'b1;
		pulse(1'b1, 16'h0080, 12'h000, 11'h000);
		chk_level("alert", 1'b1, alertN);
		rd(8'h80, 16'h0002);
		wr(8'h03, 16'h0000);
		@(negedge mclk) maskVminWarn = 1'b0;
		// a low command while the core is frozen must leave no trace
		@(negedge mclk) ce = 1'b0;
		pulse(1'b1, 16'h0080, 12'h000, 11'h000);
		chk_level("frozen alert", 1'b1, alertN);
		ce = 1'b1;
		rd(8'h80, 16'h0000);
		for (int k = 0; k < 5; k++) begin
			pulse(1'b1, (k == 0) ? 16'h0200 : 16'h0C00, 12'h000, 11'h000);
			wr(8'hA4, fw[k]);
			rd(8'hA4, fe[k]);
			rd(8'h7E, fv[k] ? 16'h0040 : 16'h0000);
			rd(8'h78, fv[k] ? 16'h0002 : 16'h0000);
			chk_level("alert", ~fv[k], alertN);
			wr(8'h7E, 16'h0040);
		end
		wr(8'h98, 16'h00FF);
		rd(8'h98, 16'h0012);
		rd(8'h7E, 16'h0080);
		wr(8'h7E, 16'h0080);
		for (int p = 0; p < 2; p++) begin
			@(negedge mclk) {ssDetectLowPin, ssDetectHighPin} = (p == 0) ? 2'b01 : 2'b10;
			repeat (4) @(negedge mclk);
			{ssDetectLowPin, ssDetectHighPin} = 2'b00;
			repeat (4) @(negedge mclk);
			chk_level("alert", 1'b1, alertN);
			rd(8'h80, 16'h0008);
			wr((p == 0) ? 8'h80 : 8'h03, 16'h0008);
			rd(8'h80, 16'h0000);
		end
		@(negedge mclk) bootVout = 16'h0090;
		syncResetPinN = 1'b0;
		repeat (6) @(negedge mclk);
		chk_level("reset request", 1'b1, resetVoutRequest);
		chk("target", 16'h0100, voutTarget);
		chk_level("alert", 1'b1, alertN);
		rd(8'h80, 16'h0004);
		@(negedge mclk) syncResetPinN = 1'b1;
		repeat (4) @(negedge mclk);
		wr(8'h03, 16'h0000);
		rd(8'h80, 16'h0000);
		repeat (10) @(negedge mclk);
		if (expQ.size() != 0)
			errors++;
		summarize();
	end
endmodule : tvf_regs_test
`default_nettype wire
